// ==== lda_defines.svh ====
// Operation
// - Host access only while low-active select is low and high-active select high.
// - Otherwise data lines float and command/data, read and write strobes are ignored.
// - Serial mode while deselected clears the shift register and bit counter.
// - Data reads pass through the bus holder; addressed data arrives on second read.
// - Written byte sits in the bus holder, committed to RAM before next write.
// - While busy, every command except a status read is rejected.
// - Status read drives the busy indicator on data line seven.
// - Display RAM holds 65 rows by 132 columns, eight full pages plus one.
// - Byte bits map to eight consecutive rows, bit zero on the lowest row.
// - Host access and display readout are independent and cause no flicker.
// - Page address changes only through the page set command.
// - Page eight is the single extra row; only data bit zero is kept.
// - Column address increments by one after every display data read or write.
// - Column increment stops at 83h and never advances the page.
// - Segment direction bit reverses the column to segment output mapping.
// - Start line row shows on first common output, or last when commons reversed.
// - Display spans 65 lines from the start line; changing it scrolls.
// - Normal/reverse and all-on act only on the output latch; on/off also drives display-off.
// - Timing generator makes line timing, latch strobe and two-frame polarity drive.
// - Master outputs polarity, line clock, display-off; slaves take timing from polarity and line clock only.
`ifndef LDA_DEFINES_SVH
`define LDA_DEFINES_SVH
`define LDA_COLS 132
`define LDA_LAST_COL 8'h83
`define LDA_EXTRA_PAGE 4'h8
`define LDA_LINES 65
`define LDA_LAST_LINE 7'h40
`define LDA_LAST_COM 7'h3F
`define LDA_RAM_WORDS 1188
`define LDA_CMD_PAGE 4'hB
`define LDA_CMD_COL_HI 4'h1
`define LDA_CMD_COL_LO 4'h0
`define LDA_BUSY_BIT 7
`define LDA_LINE_CYCLES 200
`endif

// ==== lda_pkg.sv ====
`include "lda_defines.svh"
package lda_pkg;
    typedef enum logic [1:0] {LDA_IDLE, LDA_COMMIT, LDA_FETCH} lda_phase_t;
    typedef struct packed {
        logic select_low_active_b;
        logic select_high_active;
        logic command_data_select;
        logic rd_b;
        logic wr_b;
        logic [7:0] data;
    } lda_bus_t;
    typedef struct packed {
        logic display_on;
        logic display_reverse;
        logic all_points_on;
        logic segment_reverse;
        logic common_reverse;
        logic [5:0] start_line;
    } lda_mode_t;
    typedef struct packed {
        logic lc_polarity_signal;
        logic line_clock_signal;
        logic display_off_signal_b;
    } lda_timing_t;
    typedef struct packed {
        logic [15:0] cnt;
        logic [6:0] line;
        logic pol;
        logic lclk;
        logic dof_b;
    } lda_tgen_t;
    typedef struct packed {
        logic [3:0] page;
        logic [7:0] col;
        logic [7:0] holder;
        lda_phase_t phase;
        logic [7:0] dout;
        logic rd_q;
        logic wr_q;
        logic sclk_q;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic [`LDA_COLS-1:0] linebuf;
        logic [`LDA_COLS-1:0] seg;
        logic [6:0] buf_line;
        logic [6:0] com;
        logic [7:0] sweep;
    } lda_state_t;
endpackage

// ==== lda_timing.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lda_defines.svh"
module lda_timing import lda_pkg::*; #(
    parameter int LINE_CYCLES = `LDA_LINE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic master_select_i,
    input wire logic display_on_i,
    input wire lda_timing_t timing_i,
    output logic line_adv_o,
    output logic [6:0] line_o,
    output lda_timing_t timing_o
);
    localparam logic [15:0] LAST_CNT = 16'(LINE_CYCLES - 1);
    localparam logic [15:0] HALF_CNT = 16'(LINE_CYCLES / 2);

    // Readout sweeps every column once per line, so a line must outlast the sweep
    if (LINE_CYCLES < `LDA_COLS + 2 || LINE_CYCLES > 65535) begin : g_chk
        $error("LINE_CYCLES out of range");
    end

    lda_tgen_t st;
    lda_tgen_t nx;
    logic adv;

    assign adv = master_select_i ? (st.cnt == LAST_CNT) : (!st.lclk && timing_i.line_clock_signal);

    always_comb begin
        nx = st;
        nx.dof_b = display_on_i;
        if (master_select_i) begin
            nx.cnt = adv ? 16'h0000 : 16'(st.cnt + 16'h0001);
            nx.lclk = nx.cnt < HALF_CNT;
        end else begin
            nx.cnt = 16'h0000;
            nx.lclk = timing_i.line_clock_signal;
        end
        if (adv) begin
            nx.line = (st.line == `LDA_LAST_LINE) ? 7'h00 : 7'(st.line + 7'h01);
        end
        if (master_select_i) begin
            if (adv && st.line == `LDA_LAST_LINE) begin
                nx.pol = !st.pol;
            end
        end else begin
            nx.pol = timing_i.lc_polarity_signal;
            if (nx.pol != st.pol) begin
                nx.line = 7'h00;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign line_adv_o = adv;
    assign line_o = st.line;
    assign timing_o.lc_polarity_signal = st.pol;
    assign timing_o.line_clock_signal = st.lclk;
    assign timing_o.display_off_signal_b = st.dof_b;

    line_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (adv && st.line == `LDA_LAST_LINE) |=> (st.line == 7'h00 && line_o == 7'h00))
        else $error("line counter did not wrap");
    pol_flip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (master_select_i && adv && st.line == `LDA_LAST_LINE) ##1 master_select_i
        |-> timing_o.lc_polarity_signal != $past(timing_o.lc_polarity_signal))
        else $error("polarity did not flip at frame end");
    slave_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!master_select_i) |=> timing_o.lc_polarity_signal == $past(timing_i.lc_polarity_signal))
        else $error("slave polarity not taken from master");
endmodule
`default_nettype wire

// ==== lda_ram_access.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lda_defines.svh"
module lda_ram_access import lda_pkg::*; #(
    parameter int LINE_CYCLES = `LDA_LINE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire lda_bus_t bus_i,
    input wire logic serial_select_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire lda_mode_t mode_i,
    input wire logic master_select_i,
    input wire lda_timing_t timing_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic busy_o,
    output logic [`LDA_COLS-1:0] segment_o,
    output logic [6:0] common_o,
    output lda_timing_t timing_o
);
    function automatic logic [10:0] ram_idx(input logic [3:0] page, input logic [7:0] col);
        ram_idx = 11'(11'(page) * 11'(`LDA_COLS) + 11'(col));
    endfunction

    // Extra page keeps bit zero only
    function automatic logic [7:0] page_mask(input logic [3:0] page, input logic [7:0] d);
        page_mask = (page == `LDA_EXTRA_PAGE) ? {7'h00, d[0]} : d;
    endfunction

    logic [7:0] ram [0:`LDA_RAM_WORDS-1];

    lda_state_t st;
    lda_state_t nx;
    logic par_sel, ser_sel, sclk_rise, ser_done;
    logic rd_evt, wr_evt, busy;
    logic data_wr, cmd_wr, data_rd, stat_rd;
    logic [7:0] wr_byte;
    logic ram_we;
    logic [7:0] host_rdata;
    logic [6:0] disp_row;
    logic [7:0] disp_word;
    logic disp_bit;
    logic line_adv;
    logic [6:0] line;
    logic [`LDA_COLS-1:0] fmt;

    assign par_sel = !serial_select_i && !bus_i.select_low_active_b && bus_i.select_high_active;
    assign ser_sel = serial_select_i && !bus_i.select_low_active_b && bus_i.select_high_active;
    assign sclk_rise = ser_sel && !st.sclk_q && serial_clk_i;
    assign ser_done = sclk_rise && st.bitcnt == 3'h7;
    assign rd_evt = par_sel && st.rd_q && !bus_i.rd_b;
    assign wr_evt = (par_sel && st.wr_q && !bus_i.wr_b) || ser_done;
    assign wr_byte = ser_done ? {st.shreg[6:0], serial_data_i} : bus_i.data;
    assign busy = st.phase != LDA_IDLE;
    // Busy blocks all but status read
    assign data_wr = wr_evt && bus_i.command_data_select && !busy;
    assign cmd_wr = wr_evt && !bus_i.command_data_select && !busy;
    assign data_rd = rd_evt && bus_i.command_data_select && !busy;
    assign stat_rd = rd_evt && !bus_i.command_data_select;

    assign ram_we = st.phase == LDA_COMMIT && st.col <= `LDA_LAST_COL;
    assign host_rdata = (st.col <= `LDA_LAST_COL) ? page_mask(st.page, ram[ram_idx(st.page, st.col)]) : 8'h00;

    // Row follows start line, modulo 65
    always_comb begin
        disp_row = 7'(7'(mode_i.start_line) + st.buf_line);
        if (disp_row >= 7'(`LDA_LINES)) begin
            disp_row = 7'(disp_row - 7'(`LDA_LINES));
        end
    end
    // Bit zero sits on lowest row of page
    assign disp_word = ram[ram_idx(disp_row[6:3], st.sweep)];
    assign disp_bit = disp_word[disp_row[2:0]];

    // Commit the held byte, one cycle after capture
    always_ff @(posedge clk_i) begin
        if (ram_we) begin
            ram[ram_idx(st.page, st.col)] <= page_mask(st.page, st.holder);
        end
    end

    lda_timing #(
        .LINE_CYCLES(LINE_CYCLES)
    ) i_lda_timing (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .master_select_i(master_select_i),
        .display_on_i(mode_i.display_on),
        .timing_i(timing_i),
        .line_adv_o(line_adv),
        .line_o(line),
        .timing_o(timing_o)
    );

    always_comb begin
        for (int s = 0; s < `LDA_COLS; s++) begin
            fmt[s] = mode_i.segment_reverse ? st.linebuf[`LDA_COLS - 1 - s] : st.linebuf[s];
        end
        if (mode_i.all_points_on) begin
            fmt = '1;
        end else if (mode_i.display_reverse) begin
            fmt = ~fmt;
        end
        if (!mode_i.display_on) begin
            fmt = '0;
        end
    end

    always_comb begin
        nx = st;
        nx.rd_q = bus_i.rd_b || !par_sel;
        nx.wr_q = bus_i.wr_b || !par_sel;
        nx.sclk_q = serial_clk_i;
        if (serial_select_i && !ser_sel) begin
            nx.shreg = 8'h00;
            nx.bitcnt = 3'h0;
        end else if (sclk_rise) begin
            nx.shreg = {st.shreg[6:0], serial_data_i};
            nx.bitcnt = 3'(st.bitcnt + 3'h1);
        end
        case (st.phase)
            LDA_COMMIT, LDA_FETCH: begin
                if (st.phase == LDA_FETCH) begin
                    nx.holder = host_rdata;
                end
                if (st.col < `LDA_LAST_COL) begin
                    nx.col = 8'(st.col + 8'h01);
                end
                nx.phase = LDA_IDLE;
            end
            LDA_IDLE: begin
                if (cmd_wr) begin
                    case (wr_byte[7:4])
                        `LDA_CMD_PAGE: begin
                            if (wr_byte[3:0] <= `LDA_EXTRA_PAGE) begin
                                nx.page = wr_byte[3:0];
                            end
                        end
                        `LDA_CMD_COL_HI: nx.col[7:4] = wr_byte[3:0];
                        `LDA_CMD_COL_LO: nx.col[3:0] = wr_byte[3:0];
                        default: ;
                    endcase
                end else if (data_wr) begin
                    nx.holder = wr_byte;
                    nx.phase = LDA_COMMIT;
                end else if (data_rd) begin
                    nx.dout = st.holder;
                    nx.phase = LDA_FETCH;
                end
            end
            default: nx.phase = LDA_IDLE;
        endcase
        if (stat_rd) begin
            nx.dout = 8'h00;
            nx.dout[`LDA_BUSY_BIT] = busy;
        end
        // Readout sweep owns its own read port
        if (line_adv) begin
            nx.seg = fmt;
            if (st.buf_line == `LDA_LAST_LINE) begin
                nx.com = `LDA_LAST_LINE;
            end else if (mode_i.common_reverse) begin
                nx.com = 7'(`LDA_LAST_COM - st.buf_line);
            end else begin
                nx.com = st.buf_line;
            end
            nx.buf_line = line;
            nx.sweep = 8'h00;
        end else if (st.sweep < 8'(`LDA_COLS)) begin
            nx.linebuf[st.sweep] = disp_bit;
            nx.sweep = 8'(st.sweep + 8'h01);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
            st.rd_q <= 1'b1;
            st.wr_q <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    assign data_o = st.dout;
    assign data_oe_o = par_sel && !bus_i.rd_b;
    assign busy_o = busy;
    assign segment_o = st.seg;
    assign common_o = st.com;

    sel_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!par_sel && !ser_sel && st.phase == LDA_IDLE) |=> ($stable(st.col) && $stable(st.page)))
        else $error("address moved while deselected");
    hiz_out_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!par_sel) |-> !data_oe_o)
        else $error("data driven while deselected");
    ser_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (serial_select_i && !ser_sel) |=> (st.bitcnt == 3'h0 && st.shreg == 8'h00))
        else $error("serial shifter not cleared");
    read_pipe_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        data_rd |=> (data_o == $past(st.holder)) ##1 (st.holder == $past(host_rdata)))
        else $error("read not pipelined through holder");
    commit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        data_wr |=> (ram_we || st.col > `LDA_LAST_COL) ##1 (st.phase == LDA_IDLE))
        else $error("write not committed in time");
    busy_reject_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (busy && wr_evt) |=> ($stable(st.page) && st.phase == LDA_IDLE))
        else $error("command taken while busy");
    status_d7_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        stat_rd |=> (data_o[`LDA_BUSY_BIT] == $past(busy) && data_o[6:0] == 7'h00))
        else $error("busy not on data line seven");
    col_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (busy && st.col < `LDA_LAST_COL) |=> st.col == 8'($past(st.col) + 8'h01))
        else $error("column did not increment");
    col_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (busy && st.col == `LDA_LAST_COL) |=> (st.col == `LDA_LAST_COL && $stable(st.page)))
        else $error("column passed its last value");
    page_cmd_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !$stable(st.page) |-> $past(cmd_wr))
        else $error("page moved without command");
endmodule
`default_nettype wire

// ==== lda_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lda_host import lda_pkg::*; (
    input wire logic clk_i,
    input wire logic [7:0] data_i,
    input wire logic data_oe_i,
    input wire logic busy_i,
    output lda_bus_t bus_o,
    output logic serial_select_o,
    output logic serial_clk_o,
    output logic serial_data_o
);
    initial begin
        bus_o = {2'b10, 1'b0, 1'b1, 1'b1, 8'h00};
        serial_select_o = 1'b0;
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
    end

    // selects held with the strobe for the whole access
    task automatic acc(input logic [1:0] sel, input logic cds, input logic rd, input logic [7:0] d,
                       output logic [7:0] q, output logic oe, output logic bz);
        @(posedge clk_i);
        serial_select_o <= 1'b0;
        bus_o <= {sel, cds, ~rd, rd, d};
        @(posedge clk_i);
        // Busy stands for one cycle only, so look right after the taking edge
        @(negedge clk_i);
        // Undriven data lines show the inverse, so a floating bus never looks valid
        q = data_oe_i ? data_i : ~data_i;
        oe = data_oe_i;
        bz = busy_i;
        @(posedge clk_i);
        // strobe back high, spacing kept instead of busy polling
        bus_o <= {2'b10, ~cds, 1'b1, 1'b1, ~d};
        repeat (2) @(posedge clk_i);
    endtask

    // Serial clock stands still outside frames; a short frame models an aborted transfer
    task automatic ser(input logic cds, input logic [7:0] d, input int nbits);
        int i;
        @(posedge clk_i);
        serial_select_o <= 1'b1;
        bus_o <= {2'b01, cds, 1'b1, 1'b1, 8'h00};
        for (i = 7; i > 7 - nbits; i--) begin
            serial_data_o <= d[i];
            repeat (2) @(posedge clk_i);
            serial_clk_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            serial_clk_o <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        bus_o <= {2'b10, cds, 1'b1, 1'b1, 8'hFF};
        serial_data_o <= ~d[8 - nbits];
        repeat (3) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ==== lda_ram_access_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lda_defines.svh"
module lda_ram_access_test import lda_pkg::*; ;
    localparam int LINE_CYCLES = 140;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    lda_bus_t bus;
    logic serial_select;
    logic serial_clk;
    logic serial_data;
    lda_mode_t mode = {1'b1, 4'h0, 6'h00};
    lda_timing_t timing_in = '0;
    logic master = 1'b1;
    logic [7:0] data;
    logic data_oe;
    logic busy;
    logic [`LDA_COLS-1:0] segment;
    logic [6:0] common;
    lda_timing_t timing;
    logic [7:0] q;
    logic oe;
    logic bz;
    logic pol;
    int mismatches = 0;
    int n_checks = 0;

    always #5 clk_i = ~clk_i;

    lda_ram_access #(.LINE_CYCLES(LINE_CYCLES)) i_lda_ram_access (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .bus_i(bus), .serial_select_i(serial_select), .serial_clk_i(serial_clk), .serial_data_i(serial_data),
        .mode_i(mode), .master_select_i(master), .timing_i(timing_in), .data_o(data), .data_oe_o(data_oe),
        .busy_o(busy), .segment_o(segment), .common_o(common), .timing_o(timing));

    lda_host i_lda_host (.clk_i(clk_i), .data_i(data), .data_oe_i(data_oe), .busy_i(busy), .bus_o(bus),
        .serial_select_o(serial_select), .serial_clk_o(serial_clk), .serial_data_o(serial_data));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic cds, input logic [7:0] d);
        i_lda_host.acc(2'b01, cds, 1'b0, d, q, oe, bz);
        if (cds) chk({7'h00, bz}, 8'h01);
    endtask

    task automatic rd();
        i_lda_host.acc(2'b01, 1'b1, 1'b1, 8'h00, q, oe, bz);
        chk({7'h00, oe}, 8'h01);
    endtask

    // Page first, then column high and low nibbles
    task automatic at(input logic [3:0] p, input logic [7:0] c);
        wr(1'b0, {`LDA_CMD_PAGE, p});
        wr(1'b0, {`LDA_CMD_COL_HI, c[7:4]});
        wr(1'b0, {`LDA_CMD_COL_LO, c[3:0]});
    endtask

    task automatic line(input logic [6:0] n);
        int k;
        k = 0;
        @(negedge clk_i);
        while (common === n && k < 20000) begin
            @(negedge clk_i);
            k++;
        end
        while (common !== n && k < 20000) begin
            @(negedge clk_i);
            k++;
        end
        chk({1'b0, common}, {1'b0, n});
    endtask

    task automatic setm(input logic on, input logic rev, input logic all, input logic sr, input logic [5:0] sl);
        @(posedge clk_i);
        mode <= {on, rev, all, sr, 1'b0, sl};
    endtask

    task automatic t_rw();
        at(4'h0, 8'h00);
        wr(1'b1, 8'hA5);
        wr(1'b1, 8'h3C);
        at(4'h0, 8'h00);
        rd();
        rd();
        chk(q, 8'hA5);
        rd();
        chk(q, 8'h3C);
        i_lda_host.acc(2'b01, 1'b0, 1'b1, 8'h00, q, oe, bz);
        chk(q, 8'h00);
    endtask

    task automatic t_edges();
        at(4'h8, 8'h05);
        wr(1'b1, 8'hFF);
        at(4'h2, 8'h00);
        wr(1'b1, 8'h44);
        at(4'h1, 8'h82);
        wr(1'b1, 8'h11);
        wr(1'b1, 8'h22);
        wr(1'b1, 8'h33);
        at(4'h8, 8'h05);
        rd();
        rd();
        chk(q, 8'h01);
        at(4'h1, 8'h82);
        rd();
        rd();
        chk(q, 8'h11);
        rd();
        chk(q, 8'h33);
        at(4'h2, 8'h00);
        rd();
        rd();
        chk(q, 8'h44);
    endtask

    task automatic t_select();
        at(4'h0, 8'h10);
        wr(1'b1, 8'h5A);
        // Point back at the written byte so a leaked write would land on it
        at(4'h0, 8'h10);
        for (int i = 0; i < 4; i++) begin
            if (i != 1) begin
                i_lda_host.acc(2'(i), 1'b1, 1'b0, 8'hFF, q, oe, bz);
                chk({7'h00, bz}, 8'h00);
                i_lda_host.acc(2'(i), 1'b1, 1'b1, 8'h00, q, oe, bz);
                chk({7'h00, oe}, 8'h00);
            end
        end
        at(4'h0, 8'h10);
        rd();
        rd();
        chk(q, 8'h5A);
        at(4'h0, 8'h20);
        i_lda_host.ser(1'b1, 8'hC3, 3);
        i_lda_host.ser(1'b1, 8'h96, 8);
        at(4'h0, 8'h20);
        rd();
        rd();
        chk(q, 8'h96);
    endtask

    task automatic t_display();
        at(4'h0, 8'h00);
        wr(1'b1, 8'h02);
        line(7'h20);
        line(7'h00);
        chk({7'h00, segment[0]}, 8'h00);
        line(7'h01);
        chk({7'h00, segment[0]}, 8'h01);
        setm(1'b1, 1'b0, 1'b0, 1'b0, 6'h01);
        line(7'h00);
        chk({7'h00, segment[0]}, 8'h01);
        // Polarity flips one line ahead of the extra row, so sample it as the frame starts on common zero
        pol = timing.lc_polarity_signal;
        line(`LDA_LAST_LINE);
        chk({7'h00, segment[0]}, 8'h00);
        chk({7'h00, timing.lc_polarity_signal}, {7'h00, ~pol});
        setm(1'b1, 1'b0, 1'b0, 1'b1, 6'h01);
        line(7'h00);
        chk({7'h00, segment[`LDA_COLS-1]}, 8'h01);
        setm(1'b1, 1'b1, 1'b0, 1'b1, 6'h01);
        line(7'h00);
        chk({7'h00, segment[`LDA_COLS-1]}, 8'h00);
        setm(1'b0, 1'b0, 1'b1, 1'b1, 6'h01);
        line(7'h00);
        chk({7'h00, segment[`LDA_COLS-1]}, 8'h00);
        chk({7'h00, timing.display_off_signal_b}, 8'h00);
        at(4'h0, 8'h00);
        rd();
        rd();
        chk(q, 8'h02);
    endtask

    // RAM powers up unknown; clear every page so fetches and readout are defined
    task automatic t_clear();
        for (int p = 0; p < 9; p++) begin
            at(4'(p), 8'h00);
            for (int c = 0; c < `LDA_COLS; c++) begin
                wr(1'b1, 8'h00);
            end
        end
    endtask

    // Slave takes line clock and polarity from the master pins
    task automatic t_slave();
        @(posedge clk_i);
        master <= 1'b0;
        repeat (4) @(posedge clk_i);
        timing_in.lc_polarity_signal <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int n = 0; n < 3; n++) begin
            timing_in.line_clock_signal <= 1'b1;
            repeat (70) @(posedge clk_i);
            timing_in.line_clock_signal <= 1'b0;
            repeat (70) @(posedge clk_i);
        end
        @(negedge clk_i);
        chk({1'b0, common}, 8'h01);
        chk({7'h00, timing.lc_polarity_signal}, 8'h01);
        chk({7'h00, timing.line_clock_signal}, 8'h00);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_clear();
        t_rw();
        t_edges();
        t_select();
        t_display();
        t_slave();
        wrap_up();
    end

    // Display checks need about six frames of 65 lines
    initial begin
        #1_000_000;
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
